/* core/cif_input_stage.sv */
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
// What this block does
// - Sizes 00/01/10: mantissa to bit 5/4/3, exponent 2:0
// - Size 11: mantissa bits 15:2, exponent 1:0
// - Capture sample delay clocks after strobe
// - Eight streams; delays zero through seven valid
// - Captured sample presented at next strobe
// - Gated: oscillator and filter advance on strobe
// - Interpolated: filter every clock, oscillator on strobe
// - Interpolated: sample zeroed while strobe high
// - Floating split only in floating mode
// - Size sets exponent offset and shift saturation
module cif_input_stage (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output wire logic [31:0] wb_dat_o,
  output wire logic        wb_ack_o,
  // Sample pins from the external source
  input  wire logic [15:0] sample_i,
  input  wire logic        input_sample_strobe_i,
  // Feed to the mixer stage
  output wire logic [15:0] filt_mant_o,
  output wire logic [3:0]  filt_shift_o,
  output wire logic        carrier_oscillator_adv_o,
  output wire logic        integrator_comb_filter_adv_o,
  // Realigned sample stream through the buffer
  output wire logic        str_valid_o,
  input  wire logic        str_ready_i,
  output wire logic [19:0] str_data_o
);

  // ----------------------------------------------------------------
  // Local sizes
  // ----------------------------------------------------------------
  localparam int SW = cif_pkg::SAMPLE_W;
  localparam int HW = cif_pkg::SHIFT_W;
  localparam int LW = $clog2(cif_pkg::FIFO_DEPTH+1);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [SW-1:0] smp_m_r;   // First stage, read only by second
  logic [SW-1:0] smp_s_r;   // Safe sample
  logic          stb_m_r;   // First stage, read only by second
  logic          stb_s_r;   // Safe strobe

  // Two flops on every pin; sample and strobe keep their alignment
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      smp_m_r <= '0;
      smp_s_r <= '0;
      stb_m_r <= 1'b0;
      stb_s_r <= 1'b0;
    end
    else
    begin
      smp_m_r <= sample_i;
      smp_s_r <= smp_m_r;
      stb_m_r <= input_sample_strobe_i;
      stb_s_r <= stb_m_r;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [cif_pkg::CTRL_W-1:0] ctrl_r;  // Control word
  logic                       ovf_r;   // Sticky buffer overflow
  logic                       ack_r;   // Bus acknowledge
  logic [31:0]                rdat_r;  // Read data
  wire logic [LW-1:0]         lvl_w;   // Buffer fill level

  wire logic [7:0] adr_w   = wb_adr_i & cif_pkg::ADDR_MASK;
  wire logic       req_w   = wb_cyc_i && wb_stb_i && !ack_r;
  wire logic       wr_w    = req_w && wb_we_i;
  wire logic       ctl_hit = (adr_w == cif_pkg::CTRL_ADDR);
  wire logic       sts_hit = (adr_w == cif_pkg::STAT_ADDR);

  // Field views of the control word
  wire logic       float_w  = ctrl_r[cif_pkg::FLOAT_BIT];
  wire logic [1:0] msz_w    = ctrl_r[cif_pkg::MSZ_HI:cif_pkg::MSZ_LO];
  wire logic [2:0] dly_w    = ctrl_r[cif_pkg::DLY_HI:cif_pkg::DLY_LO];
  wire logic       interp_w = ctrl_r[cif_pkg::INTERP_BIT];

  // Read mux; unmapped words read as zero but are still acked
  wire logic [31:0] ctl_rd_w = {{(32-cif_pkg::CTRL_W){1'b0}}, ctrl_r};
  wire logic [31:0] sts_rd_w = {{(32-cif_pkg::LVL_LO-LW){1'b0}}, lvl_w,
                                3'h0, ovf_r};
  wire logic [31:0] rd_w     = ctl_hit ? ctl_rd_w :
                               sts_hit ? sts_rd_w : 32'h0000_0000;

  // Byte lanes: control spans lanes 0 and 1
  wire logic [cif_pkg::CTRL_W-1:0] ctl_wr_w =
    {wb_sel_i[1] ? wb_dat_i[9:8] : ctrl_r[9:8],
     wb_sel_i[0] ? wb_dat_i[7:0] : ctrl_r[7:0]};
  wire logic ovf_clr_w = wr_w && sts_hit && wb_sel_i[0] &&
                         wb_dat_i[cif_pkg::OVF_BIT];

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // Ack one cycle after the request, dropped the next cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r  <= 1'b0;
      rdat_r <= '0;
      ctrl_r <= cif_pkg::CTRL_RST;
    end
    else
    begin
      ack_r  <= req_w;
      rdat_r <= req_w ? rd_w : 32'h0000_0000;
      if (wr_w && ctl_hit)
        ctrl_r <= ctl_wr_w;
    end
  end

  // ----------------------------------------------------------------
  // Demultiplex delay counter
  // ----------------------------------------------------------------
  logic [2:0] cnt_r;    // Clocks left until capture
  logic       armed_r;  // Capture pending for this strobe

  // Delay zero captures in the strobe cycle itself
  wire logic cap_w = (stb_s_r && dly_w == 3'h0) ||
                     (!stb_s_r && armed_r && cnt_r == 3'h1);

  // A fresh strobe always reloads, so a late count never leaks
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_r   <= 3'h0;
      armed_r <= 1'b0;
    end
    else if (stb_s_r)
    begin
      cnt_r   <= dly_w;
      armed_r <= (dly_w != 3'h0);
    end
    else if (armed_r)
    begin
      cnt_r   <= cnt_r - 3'h1;
      armed_r <= (cnt_r != 3'h1);
    end
  end

  // ----------------------------------------------------------------
  // Format decode
  // ----------------------------------------------------------------
  // Mantissa is left-justified; unused low bits become zero
  wire logic [SW-1:0] mant_fl_w =
    (msz_w == cif_pkg::MSZ_11_3) ? {smp_s_r[15:5], 5'h00} :
    (msz_w == cif_pkg::MSZ_12_3) ? {smp_s_r[15:4], 4'h0}  :
    (msz_w == cif_pkg::MSZ_13_3) ? {smp_s_r[15:3], 3'h0}  :
                                   {smp_s_r[15:2], 2'h0};
  wire logic [2:0] exp_w = (msz_w == cif_pkg::MSZ_14_2) ?
                           {1'b0, smp_s_r[1:0]} :
                           smp_s_r[2:0];
  wire logic [HW-1:0] ofs_w =
    (msz_w == cif_pkg::MSZ_11_3) ? cif_pkg::EXP_OFS_0 :
    (msz_w == cif_pkg::MSZ_12_3) ? cif_pkg::EXP_OFS_1 :
    (msz_w == cif_pkg::MSZ_13_3) ? cif_pkg::EXP_OFS_2 :
                                   cif_pkg::EXP_OFS_3;
  wire logic [HW-1:0] sat_w =
    (msz_w == cif_pkg::MSZ_11_3) ? cif_pkg::SHF_SAT_0 :
    (msz_w == cif_pkg::MSZ_12_3) ? cif_pkg::SHF_SAT_1 :
    (msz_w == cif_pkg::MSZ_13_3) ? cif_pkg::SHF_SAT_2 :
                                   cif_pkg::SHF_SAT_3;
  // One spare bit keeps the sum from wrapping before the clamp
  wire logic [HW:0]   sum_w   = {2'b00, exp_w} + {1'b0, ofs_w};
  wire logic [HW-1:0] shf_fl_w = (sum_w > {1'b0, sat_w}) ? sat_w :
                                 sum_w[HW-1:0];
  // Fixed point passes the bus through with no shift
  wire logic [SW-1:0] mant_w = float_w ? mant_fl_w : smp_s_r;
  wire logic [HW-1:0] shf_w  = float_w ? shf_fl_w : 4'h0;

  // ----------------------------------------------------------------
  // Capture, realignment and filter feed
  // ----------------------------------------------------------------
  logic [SW-1:0] cap_mant_r;   // Sample taken for this channel
  logic [HW-1:0] cap_shf_r;    // Its shift control
  logic          cap_ok_r;     // A capture has happened
  logic [SW-1:0] pres_mant_r;  // Realigned at the strobe
  logic [HW-1:0] pres_shf_r;   // Realigned shift
  logic [SW-1:0] filt_mant_r;  // Value seen by the filter
  logic [HW-1:0] filt_shf_r;   // Shift seen by the filter
  logic          osc_adv_r;    // Oscillator step
  logic          flt_adv_r;    // Filter step

  // Capture at the counted clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cap_mant_r <= '0;
      cap_shf_r  <= '0;
      cap_ok_r   <= 1'b0;
    end
    else if (cap_w)
    begin
      cap_mant_r <= mant_w;
      cap_shf_r  <= shf_w;
      cap_ok_r   <= 1'b1;
    end
  end

  // Every delay lands on the next strobe, whatever the stream
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pres_mant_r <= '0;
      pres_shf_r  <= '0;
    end
    else if (stb_s_r)
    begin
      pres_mant_r <= cap_mant_r;
      pres_shf_r  <= cap_shf_r;
    end
  end

  // Zeroing reads the strobe literally: high level, not pulse edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      filt_mant_r <= '0;
      filt_shf_r  <= '0;
      osc_adv_r   <= 1'b0;
      flt_adv_r   <= 1'b0;
    end
    else
    begin
      filt_mant_r <= (interp_w && stb_s_r) ? '0 : pres_mant_r;
      filt_shf_r  <= (interp_w && stb_s_r) ? '0 : pres_shf_r;
      osc_adv_r   <= stb_s_r;
      flt_adv_r   <= interp_w || stb_s_r;
    end
  end

  assign filt_mant_o                  = filt_mant_r;
  assign filt_shift_o                 = filt_shf_r;
  assign carrier_oscillator_adv_o     = osc_adv_r;
  assign integrator_comb_filter_adv_o = flt_adv_r;

  // ----------------------------------------------------------------
  // Realigned sample buffer
  // ----------------------------------------------------------------
  wire logic push_w = stb_s_r && cap_ok_r;  // One word per strobe
  wire logic in_rdy_w;                      // Room in the buffer

  // A full buffer drops the word; the sticky bit tells software
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ovf_r <= 1'b0;
    else if (push_w && !in_rdy_w)
      ovf_r <= 1'b1;                        // Set beats clear
    else if (ovf_clr_w)
      ovf_r <= 1'b0;
  end

  cif_fifo #(
    .WIDTH (SW + HW),
    .DEPTH (cif_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push_w),
    .in_ready_o  (in_rdy_w),
    .in_data_i   ({cap_shf_r, cap_mant_r}),
    .out_valid_o (str_valid_o),
    .out_ready_i (str_ready_i),
    .out_data_o  (str_data_o),
    .level_o     (lvl_w)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_delay_capture: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (stb_s_r && dly_w == 3'h3) ##1 (!stb_s_r && dly_w == 3'h3) [*3]
      |-> cap_w)
    else $error("capture not taken three clocks after strobe");

  chk_zero_delay: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (stb_s_r && dly_w == 3'h0) |-> cap_w ##1 !armed_r)
    else $error("zero delay did not capture at strobe");

  chk_strobe_restart: assert property (
    @(posedge clk_i) disable iff (rst_i)
    stb_s_r |=> (cnt_r == $past(dly_w) && armed_r == ($past(dly_w) != 3'h0)))
    else $error("strobe did not restart delay count");

  chk_realign_next: assert property (
    @(posedge clk_i) disable iff (rst_i)
    stb_s_r |=> pres_mant_r == $past(cap_mant_r))
    else $error("sample not realigned at strobe");

  chk_gated_adv: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!interp_w && !stb_s_r) |=> (!flt_adv_r && !osc_adv_r))
    else $error("gated mode advanced without strobe");

  chk_interp_adv: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (interp_w && !stb_s_r) |=> (flt_adv_r && !osc_adv_r))
    else $error("interpolated mode step pattern wrong");

  chk_interp_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (interp_w && stb_s_r) |=> (filt_mant_r == '0 && osc_adv_r))
    else $error("sample not zeroed under strobe");

  chk_fixed_pass: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cap_w && !float_w) |=> cap_mant_r == $past(smp_s_r))
    else $error("fixed point sample altered");

  chk_exp_sat: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cap_w && float_w) |=> cap_shf_r <= $past(sat_w))
    else $error("shift control above saturation");

  chk_split_14: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cap_w && float_w && msz_w == cif_pkg::MSZ_14_2)
      |=> cap_mant_r[1:0] == 2'h0)
    else $error("14/2 mantissa low bits not clear");

  chk_split_11: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cap_w && float_w && msz_w == cif_pkg::MSZ_11_3)
      |=> cap_mant_r == {$past(smp_s_r[15:5]), 5'h00})
    else $error("11/3 mantissa split wrong");

endmodule : cif_input_stage

/* core/cif_pkg.sv */
package cif_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR    = 8'h00; // Format and demux control
  localparam logic [7:0] STAT_ADDR    = 8'h04; // Fill level and overflow
  localparam logic [7:0] ADDR_MASK    = 8'hfc; // Word-aligned decode

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int FLOAT_BIT    = 9;   // 1 selects floating point input
  localparam int MSZ_HI       = 8;   // Mantissa size select, high bit
  localparam int MSZ_LO       = 7;   // Mantissa size select, low bit
  localparam int DLY_HI       = 6;   // Demux delay, high bit
  localparam int DLY_LO       = 4;   // Demux delay, low bit
  localparam int INTERP_BIT   = 3;   // 1 selects interpolated mode
  localparam int CTRL_W       = 10;  // Implemented control bits
  localparam logic [9:0] CTRL_RST = 10'h000; // Fixed point, gated, 0 dly

  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int OVF_BIT      = 0;   // Sticky FIFO overflow, write 1
  localparam int LVL_LO       = 4;   // FIFO fill level, low bit

  // ----------------------------------------------------------------
  // Mantissa size codes
  // ----------------------------------------------------------------
  localparam logic [1:0] MSZ_11_3 = 2'h0;
  localparam logic [1:0] MSZ_12_3 = 2'h1;
  localparam logic [1:0] MSZ_13_3 = 2'h2;
  localparam logic [1:0] MSZ_14_2 = 2'h3;

  // ----------------------------------------------------------------
  // Exponent offset and shift saturation per mantissa size
  // ----------------------------------------------------------------
  localparam logic [3:0] EXP_OFS_0 = 4'h0;
  localparam logic [3:0] EXP_OFS_1 = 4'h1;
  localparam logic [3:0] EXP_OFS_2 = 4'h2;
  localparam logic [3:0] EXP_OFS_3 = 4'h3;
  localparam logic [3:0] SHF_SAT_0 = 4'h7;
  localparam logic [3:0] SHF_SAT_1 = 4'h8;
  localparam logic [3:0] SHF_SAT_2 = 4'h9;
  localparam logic [3:0] SHF_SAT_3 = 4'h6;

  // ----------------------------------------------------------------
  // Data path sizes
  // ----------------------------------------------------------------
  localparam int SAMPLE_W   = 16;  // Input bus width
  localparam int SHIFT_W    = 4;   // Shift control width
  localparam int FIFO_DEPTH = 16;  // Realigned sample buffer depth
  localparam int MAX_STREAMS = 8;  // Streams selectable by the delay

endpackage : cif_pkg

/* core/cif_fifo.sv */
`timescale 1ns/1ns
module cif_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       in_valid_i,
  output wire logic                       in_ready_o,
  input  wire logic [WIDTH-1:0]           in_data_i,
  output wire logic                       out_valid_o,
  input  wire logic                       out_ready_i,
  output wire logic [WIDTH-1:0]           out_data_o,
  output wire logic [$clog2(DEPTH+1)-1:0] level_o
);

  // ----------------------------------------------------------------
  // Sizes and checks
  // ----------------------------------------------------------------
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  // Power-of-two depth lets pointers wrap for free
  if (DEPTH < 2 || (DEPTH & (DEPTH-1)) != 0 || WIDTH < 1)
  begin : g_bad
    $error("cif_fifo: DEPTH must be a power of two >= 2");
  end

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem_r [DEPTH];  // Entry array
  logic [AW-1:0]    wr_ptr_r;       // Next write slot
  logic [AW-1:0]    rd_ptr_r;       // Oldest entry
  logic [LW-1:0]    cnt_r;          // Entries held

  wire logic full_w  = (cnt_r == LW'(DEPTH));
  wire logic empty_w = (cnt_r == '0);
  wire logic push_w  = in_valid_i && !full_w;
  wire logic pop_w   = out_ready_i && !empty_w;

  assign in_ready_o  = !full_w;
  assign out_valid_o = !empty_w;
  assign out_data_o  = mem_r[rd_ptr_r];
  assign level_o     = cnt_r;

  // Write side, no reset needed on the data array
  always_ff @(posedge clk_i)
  begin
    if (push_w)
      mem_r[wr_ptr_r] <= in_data_i;
  end

  // Pointer and count update
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end
    else
    begin
      if (push_w)
        wr_ptr_r <= wr_ptr_r + AW'(1);
      if (pop_w)
        rd_ptr_r <= rd_ptr_r + AW'(1);
      if (push_w && !pop_w)
        cnt_r <= cnt_r + LW'(1);
      else if (pop_w && !push_w)
        cnt_r <= cnt_r - LW'(1);
    end
  end

endmodule : cif_fifo

/* test/cif_src_model.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// External sample source
// ------------------------------------------------------------
module cif_src_model (
  input  wire logic        clk_i,
  output logic      [15:0] sample_o,
  output logic             strobe_o
);
  // Quiet pins at time zero
  initial
  begin
    sample_o = 16'h0000;
    strobe_o = 1'b0;
  end

  // Channel k carries base+k; gap gives slow or prompt framing
  task automatic send_frame(input logic [15:0] base,
                            input int          len,
                            input int          gap);
    for (int k = 0; k < len; k++)
    begin
      @(posedge clk_i);
      strobe_o <= (k == 0);
      sample_o <= base + 16'(k);
    end
    // Bus keeps toggling so stale data never looks valid
    for (int g = 0; g < gap; g++)
    begin
      @(posedge clk_i);
      strobe_o <= 1'b0;
      sample_o <= ~sample_o;
    end
  endtask : send_frame
endmodule : cif_src_model

/* test/testbench.sv */
`timescale 1ns/1ns
module testbench;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        clk_i, rst_i, cyc, stb, we, rdy, ack, sv, osc, flt;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat;
  logic [15:0] smp, mant;
  logic        strb;
  logic [3:0]  shf;
  logic [19:0] sdat;
  int          n_fail, checked, cyc_n, t_st, lat, n_osc, n_flt, zbad;
  logic        mon_int;

  cif_input_stage DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sample_i(smp),
    .input_sample_strobe_i(strb), .filt_mant_o(mant), .filt_shift_o(shf),
    .carrier_oscillator_adv_o(osc), .integrator_comb_filter_adv_o(flt),
    .str_valid_o(sv), .str_ready_i(rdy), .str_data_o(sdat));
  cif_src_model src (.clk_i(clk_i), .sample_o(smp), .strobe_o(strb));

  // ------------------------------------------------------------
  // Clock, monitor and hang guard
  // ------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Pin-strobe to oscillator-step latency and step counts
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (strb === 1'b1) t_st = cyc_n;
    if (osc === 1'b1)
    begin
      n_osc++;
      lat = cyc_n - t_st;
      if (mon_int && mant !== 16'h0000) zbad++;
    end
    if (flt === 1'b1) n_flt++;
    if (cyc_n == 20000)
    begin
      n_fail++;
      close_out();
    end
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Classic cycle; waits for ack, only the bench timeout ends a hang
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1);
    check("wb ack lat", 32'(n), 32'd2);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] exp);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    check(nm, r, exp);
  endtask : rd

  task automatic reset_dut;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask : reset_dut

  // Expected {shift, mantissa} of a captured sample
  function automatic logic [19:0] exp_w(input logic [15:0] s,
                                        input logic fl,
                                        input logic [1:0] ms);
    logic [3:0]  e, sat;
    logic [15:0] m;
    if (!fl) return {4'h0, s};
    m = s & ~((16'h1 << ((ms == 2'h3) ? 2 : 5 - ms)) - 16'h1);
    e = (ms == 2'h3) ? {2'h0, s[1:0]} + 4'h3 : {1'h0, s[2:0]} + 4'(ms);
    sat = (ms == 2'h3) ? 4'h6 : 4'h7 + 4'(ms);
    return {(e > sat) ? sat : e, m};
  endfunction : exp_w

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rd("ctrl rst", 8'h00, 32'h0);
    rd("stat rst", 8'h04, 32'h0);
    wr(8'h00, 32'hffffffff);
    rd("ctrl rb", 8'h00, 32'h000003ff);
    wr(8'h08, 32'h00000000);
    rd("unmapped", 8'h08, 32'h0);
    rd("ctrl kept", 8'h00, 32'h000003ff);
  endtask : t_regs

  // Every delay picks channel d, realigned at the next strobe
  task automatic t_delay;
    logic [15:0] b;
    rdy <= 1'b1;
    for (int d = 0; d < 8; d++)
    begin
      wr(8'h00, 32'(d) << 4);
      b = 16'h1000 * 16'(d + 1) + 16'h00a0;
      @(negedge clk_i);
      n_osc = 0;
      n_flt = 0;
      src.send_frame(b, 8, 2);
      src.send_frame(16'h0e00, 8, 8);
      check("dly mant", {16'h0, mant}, {16'h0, b + 16'(d)});
      check("dly shf", {28'h0, shf}, 32'h0);
      check("dly lat", 32'(lat), 32'd3);
      check("gate osc", 32'(n_osc), 32'd2);
      check("gate flt", 32'(n_flt), 32'd2);
    end
  endtask : t_delay

  task automatic t_format;
    logic [15:0] s [2];
    logic [19:0] x;
    s[0] = 16'hb6f5;
    s[1] = 16'h7ffb;
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h00, 32'h200 | (32'(m) << 7));
      for (int i = 0; i < 2; i++)
      begin
        src.send_frame(s[i], 8, 2);
        src.send_frame(16'h0123, 8, 8);
        x = exp_w(s[i], 1'b1, 2'(m));
        check("flt mant", {16'h0, mant}, {16'h0, x[15:0]});
        check("flt shf", {28'h0, shf}, {28'h0, x[19:16]});
      end
    end
  endtask : t_format

  // Filter steps every clock; oscillator only per strobe
  task automatic t_interp;
    int c0;
    wr(8'h00, 32'h38);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    n_osc = 0;
    n_flt = 0;
    zbad = 0;
    mon_int = 1'b1;
    c0 = cyc_n;
    src.send_frame(16'h4440, 8, 4);
    src.send_frame(16'h5550, 8, 4);
    src.send_frame(16'h6660, 8, 8);
    @(negedge clk_i);
    mon_int = 1'b0;
    check("int flt", 32'(n_flt), 32'(cyc_n - c0));
    check("int osc", 32'(n_osc), 32'd3);
    check("int zero", 32'(zbad), 32'd0);
    check("int mant", {16'h0, mant}, 32'h5553);
  endtask : t_interp

  // Early strobe drops the pending capture; no push until a capture has happened
  task automatic t_restart;
    rdy <= 1'b0;
    reset_dut();
    wr(8'h00, 32'h50);
    src.send_frame(16'h2100, 2, 0);
    src.send_frame(16'h2200, 8, 2);
    src.send_frame(16'h2300, 8, 8);
    check("rst mant", {16'h0, mant}, 32'h2205);
    rd("rst lvl", 8'h04, 32'h10);
  endtask : t_restart

  // Fill past depth with reader stalled, then drain in order
  task automatic t_buffer;
    int n;
    reset_dut();
    for (int k = 0; k < 19; k++)
      src.send_frame({8'(k), 8'h3c}, 8, (k == 18) ? 8 : 2);
    rd("full", 8'h04, 32'h101);
    wr(8'h04, 32'h1);
    rd("ovf clr", 8'h04, 32'h100);
    @(negedge clk_i);
    for (int k = 0; k < 16; k++)
    begin
      n = 0;
      while (sv !== 1'b1 && n < 20)
      begin
        @(negedge clk_i);
        n++;
      end
      check("pop", {12'h0, sdat}, {12'h0, 4'h0, 8'(k), 8'h3c});
      @(posedge clk_i);
      rdy <= 1'b1;
      @(posedge clk_i);
      rdy <= 1'b0;
      @(negedge clk_i);
    end
    check("empty", {31'h0, sv}, 32'h0);
    rd("lvl 0", 8'h04, 32'h0);
  endtask : t_buffer

  // ------------------------------------------------------------
  // Main sequence and verdict
  // ------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  initial
  begin
    {rst_i, cyc, stb, we, rdy, mon_int} = 6'h20;
    {adr, wdat} = 40'h0;
    {n_fail, checked, cyc_n, t_st, lat, n_osc, n_flt, zbad} = '0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_delay();
    t_format();
    t_interp();
    t_restart();
    t_buffer();
    close_out();
  end
endmodule : testbench
